// *** core/oled_cmd_defines.svh ***
/*
 * command codes, field positions, reset values and timing counts of the
 * oled command decoder link.
 * assumes inclusion by bare name from the package and both ends.
 */
`ifndef OLED_CMD_DEFINES_SVH
`define OLED_CMD_DEFINES_SVH

`define CMD_RMW_START 8'hE0
`define CMD_RMW_END 8'hEE
`define CMD_NOP 8'hE3
`define CMD_CONTRAST 8'h81
`define CMD_MUX 8'hA8
`define CMD_CLOCK 8'hD5
`define CMD_DCDC 8'hAD
`define CMD_ROW 8'hB0
`define CMD_OFFSET 8'hD3
`define CMD_PERIOD 8'hD9
`define CMD_VCOM 8'hDB
`define CMD_VSEGM 8'hDC
`define CMD_REMAP_BASE 7'h50
`define CMD_ENTIRE_BASE 7'h52
`define CMD_REVERSE_BASE 7'h53
`define CMD_DISPLAY_BASE 7'h57

`define RST_DISCHARGE 4'h0
`define RST_START_LINE 6'h00
`define RST_CONTRAST 8'h80
`define RST_MUX 6'h3F
`define RST_CLOCK 8'h50
`define RST_COLUMN 7'h00
`define RST_MIRROR 1'b0
`define RST_ENTIRE 1'b0
`define RST_REVERSE 1'b0
`define RST_PANEL_ON 1'b0

`define STAT_BUSY_BIT 7
`define STAT_OFF_BIT 6

// reset busy time: 1.0 us at 50 MHz, longest time, rounded down
`define INIT_TIME_NS 1000
`define CLK_PERIOD_NS 20
`define INIT_CYCLES (`INIT_TIME_NS / `CLK_PERIOD_NS)

// host command port register offsets
`define HREG_CTRL 4'h0
`define HREG_CMD 4'h1
`define HREG_DATA 4'h2
`define HREG_STATUS 4'h3
`define HREG_RDATA 4'h4
`define HREG_STATE 4'h5

`endif

// *** core/oled_cmd_pkg.sv ***
/*
 * shared types of the oled command decoder link.
 * assumes the defines header is on the include path.
 */
package oled_cmd_pkg;
`include "oled_cmd_defines.svh"

    typedef enum logic [2:0] {
        prm_none,
        prm_contrast,
        prm_mux,
        prm_clock,
        prm_ignore
    } param_kind_type;

    typedef enum logic [1:0] {
        hst_idle,
        hst_read_wait,
        hst_done
    } host_state_type;
endpackage

// *** core/oled_link_if.sv ***
/*
 * host port link between microprocessor end and display controller end.
 * assumes one clock and a synchronous host strobe protocol.
 */
`timescale 1ns/1ns
interface oled_link_if;
    logic wr_stb;
    logic rd_stb;
    logic data_command_select;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic serial_mode;

    modport device (
        input wr_stb,
        input rd_stb,
        input data_command_select,
        input wdata,
        input serial_mode,
        output rdata
    );
    modport host (
        output wr_stb,
        output rd_stb,
        output data_command_select,
        output wdata,
        output serial_mode,
        input rdata
    );
endinterface

// *** core/oled_cmd_device.sv ***
/*
 * display controller end: command decode, column pointer, status and
 * display ram access of a 128x64 greyscale panel controller.
 * assumes host strobes are one cycle wide and synchronous to core_clk.
 */
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`include "oled_cmd_defines.svh"
module oled_cmd_device
    import oled_cmd_pkg::*;
#(
    parameter int COL_W = 7,
    parameter int ROW_W = 6,
    parameter int INIT_CYCLES = `INIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    oled_link_if.device link,
    input wire logic [ROW_W-1:0] row_addr,
    output logic [3:0] segment_discharge_level,
    output logic [5:0] first_common_output,
    output logic [7:0] contrast,
    output logic seg_mirror,
    output logic entire_on,
    output logic reverse,
    output logic [5:0] mux_ratio,
    output logic panel_on,
    output logic [7:0] display_clock,
    output logic rmw_active,
    output logic [COL_W-1:0] column
);
    // ************************************************************
    // parameter checks
    // ************************************************************
    // the high column command carries three bits, the busy counter is sixteen bits wide
    if (COL_W < 7 || COL_W > 8) begin : g_col_check
        $error("column width must be 7 or 8");
    end
    if (ROW_W < 1) begin : g_row_check
        $error("row width must be at least 1");
    end
    if (INIT_CYCLES < 1 || INIT_CYCLES > 65536) begin : g_init_check
        $error("busy time out of counter range");
    end

    localparam int DEPTH = (1 << COL_W) << ROW_W;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [3:0] discharge;
        logic [5:0] start_line;
        logic [7:0] contrast;
        logic mirror;
        logic entire;
        logic rev;
        logic [5:0] mux;
        logic on;
        logic [7:0] clk_set;
        logic rmw;
        logic [COL_W-1:0] col;
        logic [COL_W-1:0] col_saved;
        param_kind_type prm;
        logic busy;
        logic [15:0] init_cnt;
        logic [7:0] pipe;
        logic [7:0] rdata;
    } dev_state_type;

    // every setting lives in one register set; the ram sits beside it
    dev_state_type cur_ff;
    dev_state_type nxt_cur;
    logic [7:0] mem_ff [DEPTH];
    logic [$clog2(DEPTH)-1:0] addr;
    logic mem_we;

    assign addr = {row_addr, cur_ff.col};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [7:0] b;
        b = link.wdata;
        nxt_cur = cur_ff;
        mem_we = 1'b0;
        if (cur_ff.busy) begin
            // busy for a fixed time after reset
            if (cur_ff.init_cnt == 16'(INIT_CYCLES - 1)) begin
                nxt_cur.busy = 1'b0;
            end else begin
                nxt_cur.init_cnt = cur_ff.init_cnt + 16'h0001;
            end
        end
        if (link.rd_stb && !link.data_command_select) begin
            nxt_cur.rdata = 8'h00;
            nxt_cur.rdata[`STAT_BUSY_BIT] = cur_ff.busy;
            nxt_cur.rdata[`STAT_OFF_BIT] = !cur_ff.on;
        end
        if (link.rd_stb && link.data_command_select && !link.serial_mode) begin
            // pipelined read: returns latch, then refills it
            // the latch can go stale under a write; software re-sets the column first
            nxt_cur.rdata = cur_ff.pipe;
            nxt_cur.pipe = mem_ff[addr];
            if (!cur_ff.rmw) begin
                nxt_cur.col = cur_ff.col + COL_W'(1);
            end
        end
        // data traffic is not held off by busy; only the command path waits
        if (link.wr_stb && link.data_command_select) begin
            mem_we = 1'b1;
            nxt_cur.col = cur_ff.col + COL_W'(1);
        end
        // commands refused while busy
        if (link.wr_stb && !link.data_command_select && !cur_ff.busy) begin
            if (cur_ff.prm != prm_none) begin
                nxt_cur.prm = prm_none;
                case (cur_ff.prm)
                    prm_contrast: nxt_cur.contrast = b;
                    prm_mux: nxt_cur.mux = b[5:0];
                    prm_clock: nxt_cur.clk_set = b;
                    default: nxt_cur.prm = prm_none;
                endcase
            end else if (b[7:4] == 4'h0) begin
                nxt_cur.col[3:0] = b[3:0];
                nxt_cur.pipe = 8'h00;
            end else if (b[7:3] == 5'b00010) begin
                nxt_cur.col[6:4] = b[2:0];
                nxt_cur.pipe = 8'h00;
            end else if (b[7:4] == 4'h3) begin
                nxt_cur.discharge = b[3:0];
            end else if (b[7:6] == 2'b01) begin
                nxt_cur.start_line = b[5:0];
            end else if (b[7:1] == `CMD_REMAP_BASE) begin
                nxt_cur.mirror = b[0];
            end else if (b[7:1] == `CMD_ENTIRE_BASE) begin
                nxt_cur.entire = b[0];
            end else if (b[7:1] == `CMD_REVERSE_BASE) begin
                nxt_cur.rev = b[0];
            end else if (b[7:1] == `CMD_DISPLAY_BASE) begin
                nxt_cur.on = b[0];
            end else if (b == `CMD_CONTRAST) begin
                nxt_cur.prm = prm_contrast;
            end else if (b == `CMD_MUX) begin
                nxt_cur.prm = prm_mux;
            end else if (b == `CMD_CLOCK) begin
                nxt_cur.prm = prm_clock;
            end else if (b == `CMD_DCDC || b == `CMD_ROW || b == `CMD_OFFSET || b == `CMD_PERIOD
                    || b == `CMD_VCOM || b == `CMD_VSEGM) begin
                // parameter swallowed; its setting lives outside this block
                nxt_cur.prm = prm_ignore;
            end else if (b == `CMD_RMW_START) begin
                nxt_cur.rmw = 1'b1;
                nxt_cur.col_saved = cur_ff.col;
            end else if (b == `CMD_RMW_END) begin
                nxt_cur.rmw = 1'b0;
                // an end with no start falls back to the last saved column
                nxt_cur.col = cur_ff.col_saved;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            // power-on values of every setting
            cur_ff <= '0;
            cur_ff.discharge <= `RST_DISCHARGE;
            cur_ff.start_line <= `RST_START_LINE;
            cur_ff.contrast <= `RST_CONTRAST;
            cur_ff.mux <= `RST_MUX;
            cur_ff.clk_set <= `RST_CLOCK;
            cur_ff.col <= COL_W'(`RST_COLUMN);
            cur_ff.prm <= prm_none;
            cur_ff.mirror <= `RST_MIRROR;
            cur_ff.entire <= `RST_ENTIRE;
            cur_ff.rev <= `RST_REVERSE;
            cur_ff.on <= `RST_PANEL_ON;
            cur_ff.rmw <= 1'b0;
            cur_ff.pipe <= 8'h00;
            cur_ff.init_cnt <= 16'h0000;
            cur_ff.busy <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ram is not reset: contents are undefined at power-on anyway
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem_ff[addr] <= link.wdata;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign link.rdata = cur_ff.rdata;
    assign segment_discharge_level = cur_ff.discharge;
    assign first_common_output = cur_ff.start_line;
    assign contrast = cur_ff.contrast;
    assign seg_mirror = cur_ff.mirror;
    assign entire_on = cur_ff.entire;
    assign reverse = cur_ff.rev;
    assign mux_ratio = cur_ff.mux;
    assign panel_on = cur_ff.on;
    assign display_clock = cur_ff.clk_set;
    assign rmw_active = cur_ff.rmw;
    assign column = cur_ff.col;
endmodule

// *** core/oled_cmd_host.sv ***
/*
 * microprocessor end: turns register-port orders into link strobes
 * and captures the answer of each read.
 * assumes a plain register port master and the device end on the link.
 */
`timescale 1ns/1ns
`include "oled_cmd_defines.svh"
module oled_cmd_host
    import oled_cmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    oled_link_if.host link,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic serial;
        logic wr_stb;
        logic rd_stb;
        logic dc;
        logic [7:0] wdata;
        logic [7:0] captured;
        logic [7:0] rdata;
        host_state_type st;
    } host_reg_type;

    host_reg_type cur_ff;
    host_reg_type nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.wr_stb = 1'b0;
        nxt_cur.rd_stb = 1'b0;
        nxt_cur.rdata = 8'h00;
        case (cur_ff.st)
            hst_read_wait: nxt_cur.st = hst_done;
            hst_done: begin
                nxt_cur.captured = link.rdata;
                nxt_cur.st = hst_idle;
            end
            default: nxt_cur.st = hst_idle;
        endcase
        // software sends only defined codes and pairs E0H with EEH
        if (wr) begin
            case (addr)
                `HREG_CTRL: nxt_cur.serial = wdata[0];
                `HREG_CMD: begin
                    nxt_cur.wr_stb = 1'b1;
                    nxt_cur.dc = 1'b0;
                    nxt_cur.wdata = wdata;
                end
                `HREG_DATA: begin
                    nxt_cur.wr_stb = 1'b1;
                    nxt_cur.dc = 1'b1;
                    nxt_cur.wdata = wdata;
                end
                default: nxt_cur.wdata = cur_ff.wdata;
            endcase
        end
        if (rd) begin
            case (addr)
                `HREG_CTRL: nxt_cur.rdata = {7'h00, cur_ff.serial};
                // a read order starts a link read; data lands in captured reg
                `HREG_STATUS, `HREG_RDATA: begin
                    nxt_cur.rd_stb = 1'b1;
                    nxt_cur.dc = (addr == `HREG_RDATA);
                    nxt_cur.st = hst_read_wait;
                    nxt_cur.rdata = cur_ff.captured;
                end
                `HREG_STATE: nxt_cur.rdata = {6'h00, cur_ff.st};
                default: nxt_cur.rdata = cur_ff.captured;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_ff <= '0;
            cur_ff.st <= hst_idle;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign link.wr_stb = cur_ff.wr_stb;
    assign link.rd_stb = cur_ff.rd_stb;
    assign link.data_command_select = cur_ff.dc;
    assign link.wdata = cur_ff.wdata;
    assign link.serial_mode = cur_ff.serial;
    assign rdata = cur_ff.rdata;
endmodule

// *** dv/oled_cmd_assertions.sv ***
/*
 * link checker: status byte, busy window, dummy read and serial read rules.
 * assumes tb instantiates it beside the link, one clock, sync high reset.
 */
`timescale 1ns/1ns
`include "oled_cmd_defines.svh"
module oled_cmd_assertions #(
    parameter int INIT_CYCLES = `INIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic data_command_select,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic serial_mode
);
    // ****************************************
    // helper state
    // ****************************************
    logic [7:0] cnt_ff;
    logic prm_ff, on_ff, dummy_ff, acc, col_set, stat_rd;
    // cnt_ff mirrors the busy counter and stops at INIT_CYCLES, where commands start to land
    assign acc = wr_stb && !data_command_select && (cnt_ff == 8'(INIT_CYCLES));
    assign col_set = acc && !prm_ff && (wdata[7:4] == 4'h0 || wdata[7:3] == 5'h02);
    assign stat_rd = rd_stb && !data_command_select && !serial_mode;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_ff <= 8'h00;
            prm_ff <= 1'b0;
            on_ff <= 1'b0;
            dummy_ff <= 1'b0;
        end else begin
            if (cnt_ff < 8'(INIT_CYCLES)) cnt_ff <= cnt_ff + 8'h01;
            if (acc) prm_ff <= !prm_ff && (wdata inside {8'h81, 8'hA8, 8'hD5, 8'hAD, 8'hB0, 8'hD3,
                8'hD9, 8'hDB, 8'hDC});
            if (acc && !prm_ff && wdata[7:1] == 7'h57) on_ff <= wdata[0];
            if (col_set) dummy_ff <= 1'b1;
            else if (rd_stb && data_command_select && !serial_mode) dummy_ff <= 1'b0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_BUSY_SET: assert property (stat_rd && cnt_ff < 8'(INIT_CYCLES) |=> rdata[7])
        else $error("busy flag low during init");
    AST_BUSY_CLEAR: assert property (stat_rd && cnt_ff == 8'(INIT_CYCLES) |=> !rdata[7])
        else $error("busy flag high after init");
    AST_OFF_FLAG: assert property (stat_rd |=> rdata[6] == !$past(on_ff))
        else $error("display flag wrong");
    AST_LOW_ZERO: assert property (stat_rd |=> rdata[2:0] == 3'h0)
        else $error("status low bits not zero");
    AST_SERIAL_HOLD: assert property (rd_stb && data_command_select && serial_mode |=> $stable(rdata))
        else $error("serial data read changed answer");
    AST_DUMMY: assert property (rd_stb && data_command_select && !serial_mode && dummy_ff |=> rdata == 8'h00)
        else $error("dummy read not zero");
    AST_HOLD: assert property (!rd_stb |=> $stable(rdata))
        else $error("answer changed without read");
    AST_ONE_STROBE: assert property (!(wr_stb && rd_stb))
        else $error("both strobes high");
endmodule

// *** dv/tb.sv ***
/*
 * testbench: host end and device end joined by the link, driven via the host register port.
 * assumes host captured byte is read at any unmapped address.
 */
`timescale 1ns/1ns
module tb;
    // ****************************************
    // signals and instances
    // ****************************************
    logic core_clk = 0, rst = 1, wr = 0, rd = 0, seg_mirror, entire_on, reverse, panel_on, rmw_active;
    logic [3:0] addr = 4'h0, segment_discharge_level;
    logic [7:0] wdata = 8'h00, rdata, contrast, display_clock, cap;
    logic [5:0] row_addr = 6'h05, first_common_output, mux_ratio;
    logic [6:0] column;
    logic [7:0] seq [15] = '{8'h3A, 8'h7F, 8'hA1, 8'hA5, 8'hA7, 8'hAF, 8'h81, 8'hAE, 8'hA8, 8'h05, 8'hD5,
        8'hF3, 8'hD9, 8'h05, 8'hE3};
    int n_mismatch = 0, checked = 0;
    oled_link_if link();
    always #10 core_clk = ~core_clk;
    oled_cmd_host oled_cmd_host_inst(.core_clk, .rst, .link(link), .addr, .wdata, .wr, .rd, .rdata);
    oled_cmd_device #(.INIT_CYCLES(10)) oled_cmd_device_inst(.core_clk, .rst, .link(link), .row_addr,
        .segment_discharge_level, .first_common_output, .contrast, .seg_mirror, .entire_on, .reverse,
        .mux_ratio, .panel_on, .display_clock, .rmw_active, .column);
    oled_cmd_assertions #(.INIT_CYCLES(10)) oled_cmd_assertions_inst(.core_clk(core_clk), .rst(rst),
        .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .data_command_select(link.data_command_select),
        .wdata(link.wdata), .rdata(link.rdata), .serial_mode(link.serial_mode));
    // ****************************************
    // tasks
    // ****************************************
    task chk(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task port(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a; wdata <= d; wr <= w; rd <= !w;
        @(posedge core_clk);
        wr <= 0; rd <= 0;
    endtask
    task put(input logic [3:0] a, input logic [7:0] d);
        port(1, a, d);
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    // order a read, let it land in the capture, then fetch it
    task get(input logic [3:0] a);
        port(0, a, 8'h00);
        repeat (3) @(posedge core_clk);
        port(0, 4'h6, 8'h00);
        #1 cap = rdata;
    endtask
    task set_col(input logic [6:0] c);
        put(4'h1, {5'h02, c[6:4]});
        put(4'h1, {4'h0, c[3:0]});
    endtask
    task finish_test;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        @(posedge core_clk);
        rst <= 1;
        repeat (8) @(posedge core_clk);
        rst <= 0;
        put(4'h1, 8'hAF);
        get(4'h3); chk(8'hC0, cap);
        repeat (12) @(posedge core_clk);
        get(4'h3); chk(8'h40, cap);
        chk(8'h00, {4'h0, segment_discharge_level});
        chk(8'h00, {2'b0, first_common_output});
        chk(8'h80, contrast);
        chk(8'h3F, {2'b0, mux_ratio});
        chk(8'h50, display_clock);
        chk(8'h00, {3'b0, seg_mirror, entire_on, reverse, panel_on, rmw_active});
        chk(8'h00, {1'b0, column});
        $display("test reset done");
    endtask
    task t_settings;
        foreach (seq[i]) put(4'h1, seq[i]);
        chk(8'h0A, {4'h0, segment_discharge_level});
        chk(8'h3F, {2'b0, first_common_output});
        chk(8'h0F, {4'h0, seg_mirror, entire_on, reverse, panel_on});
        chk(8'hAE, contrast);
        chk(8'h05, {2'b0, mux_ratio});
        chk(8'hF3, display_clock);
        chk(8'h00, {1'b0, column});
        get(4'h3); chk(8'h00, cap);
        $display("test settings done");
    endtask
    task t_data;
        set_col(7'h23);
        chk(8'h23, {1'b0, column});
        put(4'h2, 8'h11); put(4'h2, 8'h22); put(4'h2, 8'h33);
        chk(8'h26, {1'b0, column});
        set_col(7'h23);
        get(4'h4); chk(8'h00, cap);
        get(4'h4); chk(8'h11, cap);
        get(4'h4); chk(8'h22, cap);
        chk(8'h26, {1'b0, column});
        @(posedge core_clk) row_addr <= 6'h06;
        set_col(7'h23);
        put(4'h2, 8'h5A);
        set_col(7'h23);
        get(4'h4);
        get(4'h4); chk(8'h5A, cap);
        @(posedge core_clk) row_addr <= 6'h05;
        set_col(7'h23);
        get(4'h4);
        get(4'h4); chk(8'h11, cap);
        $display("test data done");
    endtask
    task t_rmw;
        set_col(7'h23);
        put(4'h1, 8'hE0);
        get(4'h4); chk(8'h00, cap);
        get(4'h4); chk(8'h11, cap);
        chk(8'hA3, {rmw_active, column});
        put(4'h2, 8'h44);
        chk(8'hA4, {rmw_active, column});
        put(4'h1, 8'hEE);
        chk(8'h23, {rmw_active, column});
        set_col(7'h23);
        get(4'h4);
        get(4'h4); chk(8'h44, cap);
        $display("test rmw done");
    endtask
    task t_serial;
        put(4'h0, 8'h01);
        get(4'h4); chk(8'h44, cap);
        chk(8'h25, {1'b0, column});
        put(4'h0, 8'h00);
        $display("test serial done");
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        finish_test;
    end
    initial begin
        t_reset;
        t_settings;
        t_data;
        t_rmw;
        t_serial;
        t_reset;
        finish_test;
    end
endmodule
